//--- core/lds_core.sv
// Load decode, execute and fetch synchronize controller.
`timescale 1ns/1ps
module lds_core
	import lds_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic instr_valid_i,
	input wire logic [31:0] instr_i,
	output logic instr_ready_o,
	output logic illegal_o,
	input wire logic pipe_busy_i,
	output logic fetch_hold_o,
	output logic [4:0] base_sel_o,
	output logic [4:0] index_sel_o,
	input wire logic [31:0] base_val_i,
	input wire logic [31:0] index_val_i,
	output logic mem_req_o,
	output logic [31:0] mem_addr_o,
	output lds_size_t mem_size_o,
	input wire logic mem_ready_i,
	input wire logic mem_rvalid_i,
	input wire logic [63:0] mem_rdata_i,
	output logic gpr_wr_en_o,
	output logic [4:0] gpr_wr_idx_o,
	output logic [31:0] gpr_wr_data_o,
	output logic fpr_wr_en_o,
	output logic [4:0] fpr_wr_idx_o,
	output logic [63:0] fpr_wr_data_o,
	output logic base_wr_en_o,
	output logic [4:0] base_wr_idx_o,
	output logic [31:0] base_wr_data_o
);
	typedef enum logic [2:0] {S_IDLE, S_REQ, S_WAIT, S_WB, S_SYNC}
		lds_state_t;

	// ------------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------------
	logic [5:0] opc;
	logic [9:0] xo;
	logic [4:0] f_tgt;
	logic [4:0] f_base;
	logic dec_ok;
	logic dec_sync;
	logic dec_upd;
	logic dec_idx;
	logic dec_fp;
	logic bad_form;
	lds_kind_t dec_kind;

	assign opc = instr_i[OPC_HI:OPC_LO];
	assign xo = instr_i[XO_HI:XO_LO];
	assign f_tgt = instr_i[TGT_HI:TGT_LO];
	assign f_base = instr_i[BASE_HI:BASE_LO];

	always_comb begin
		dec_ok = 1'b1;
		dec_sync = 1'b0;
		dec_upd = 1'b0;
		dec_idx = 1'b0;
		dec_kind = LDS_K_BYTE;
		case (opc)
			OP_BYTE: dec_kind = LDS_K_BYTE;
			OP_BYTE_U: dec_upd = 1'b1;
			OP_HALF: dec_kind = LDS_K_HALF;
			OP_DBL: dec_kind = LDS_K_DBL;
			OP_DBL_U: begin
				dec_kind = LDS_K_DBL;
				dec_upd = 1'b1;
			end
			OP_SGL: dec_kind = LDS_K_SGL;
			OP_SGL_U: begin
				dec_kind = LDS_K_SGL;
				dec_upd = 1'b1;
			end
			OP_EXT: begin
				dec_idx = 1'b1;
				case (xo)
					XO_BYTE_UX: dec_upd = 1'b1;
					XO_BYTE_X: dec_kind = LDS_K_BYTE;
					XO_DBL_UX: begin
						dec_kind = LDS_K_DBL;
						dec_upd = 1'b1;
					end
					XO_DBL_X: dec_kind = LDS_K_DBL;
					XO_SGL_UX: begin
						dec_kind = LDS_K_SGL;
						dec_upd = 1'b1;
					end
					XO_SGL_X: dec_kind = LDS_K_SGL;
					default: dec_ok = 1'b0;
				endcase
			end
			OP_SYNC: begin
				dec_ok = 1'b0;
				dec_sync = (xo == XO_SYNC);
			end
			default: dec_ok = 1'b0;
		endcase
		dec_fp = (dec_kind == LDS_K_SGL) || (dec_kind == LDS_K_DBL);
		// Update forms need a real base; integer ones may not target it.
		bad_form = dec_upd && ((f_base == REG_RST) ||
			(!dec_fp && f_base == f_tgt));
	end

	// ------------------------------------------------------------------
	// Address and format helpers
	// ------------------------------------------------------------------
	lds_ld_if ld ();
	lds_kind_t kind_q;

	assign ld.base_val = base_val_i;
	assign ld.index_val = index_val_i;
	assign ld.disp = instr_i[DISP_HI:DISP_LO];
	assign ld.use_index = dec_idx;
	assign ld.zero_base = !dec_upd && (f_base == REG_RST);
	assign ld.kind = kind_q;
	assign ld.raw = mem_rdata_i;

	lds_ea u_ea (
		.ld(ld)
	);

	lds_fmt u_fmt (
		.ld(ld)
	);

	// ------------------------------------------------------------------
	// Control state
	// ------------------------------------------------------------------
	lds_state_t state_q;
	lds_state_t state_d;
	lds_kind_t kind_d;
	logic upd_q;
	logic upd_d;
	logic fp_q;
	logic fp_d;
	logic illegal_q;
	logic illegal_d;
	logic [4:0] tgt_q;
	logic [4:0] tgt_d;
	logic [4:0] base_q;
	logic [4:0] base_d;
	logic [31:0] ea_q;
	logic [31:0] ea_d;
	logic [63:0] result_q;
	logic [63:0] result_d;

	always_comb begin
		state_d = state_q;
		kind_d = kind_q;
		upd_d = upd_q;
		fp_d = fp_q;
		tgt_d = tgt_q;
		base_d = base_q;
		ea_d = ea_q;
		result_d = result_q;
		illegal_d = 1'b0;
		unique case (state_q)
			S_IDLE: begin
				if (instr_valid_i) begin
					if (dec_sync) begin
						state_d = S_SYNC;
					end else if (dec_ok && !bad_form) begin
						state_d = S_REQ;
						kind_d = dec_kind;
						upd_d = dec_upd;
						fp_d = dec_fp;
						tgt_d = f_tgt;
						base_d = f_base;
						ea_d = ld.ea;
					end else begin
						illegal_d = 1'b1;
					end
				end
			end
			S_REQ: begin
				if (mem_ready_i) begin
					state_d = S_WAIT;
				end
			end
			S_WAIT: begin
				if (mem_rvalid_i) begin
					result_d = ld.result;
					state_d = S_WB;
				end
			end
			S_WB: state_d = S_IDLE;
			S_SYNC: begin
				// Release only once nothing older remains anywhere.
				if (!pipe_busy_i) begin
					state_d = S_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_q <= S_IDLE;
			kind_q <= LDS_K_BYTE;
			upd_q <= 1'b0;
			fp_q <= 1'b0;
			illegal_q <= 1'b0;
			tgt_q <= REG_RST;
			base_q <= REG_RST;
			ea_q <= ADDR_RST;
			result_q <= DATA_RST;
		end else begin
			state_q <= state_d;
			kind_q <= kind_d;
			upd_q <= upd_d;
			fp_q <= fp_d;
			illegal_q <= illegal_d;
			tgt_q <= tgt_d;
			base_q <= base_d;
			ea_q <= ea_d;
			result_q <= result_d;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	logic wb;

	assign wb = (state_q == S_WB);
	assign instr_ready_o = (state_q == S_IDLE);
	assign illegal_o = illegal_q;
	assign fetch_hold_o = (state_q == S_SYNC) ||
		(instr_ready_o && instr_valid_i && dec_sync);
	assign base_sel_o = f_base;
	assign index_sel_o = instr_i[IDX_HI:IDX_LO];
	assign mem_req_o = (state_q == S_REQ);
	assign mem_addr_o = ea_q;
	assign mem_size_o = lds_size_of(kind_q);
	assign gpr_wr_en_o = wb && !fp_q;
	assign gpr_wr_idx_o = tgt_q;
	assign gpr_wr_data_o = result_q[31:0];
	assign fpr_wr_en_o = wb && fp_q;
	assign fpr_wr_idx_o = tgt_q;
	assign fpr_wr_data_o = result_q;
	assign base_wr_en_o = wb && upd_q;
	assign base_wr_idx_o = base_q;
	assign base_wr_data_o = ea_q;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	logic [31:0] exp_ea;
	logic take_load;

	assign exp_ea = ((!dec_upd && f_base == REG_RST) ? ADDR_RST : base_val_i)
		+ (dec_idx ? index_val_i : sign_extend_fn(instr_i[DISP_HI:DISP_LO]));
	assign take_load = instr_ready_o && instr_valid_i && dec_ok && !bad_form;

	sequence req_held;
		mem_req_o && !mem_ready_i;
	endsequence

	sequence data_back;
		(state_q == S_WAIT) && mem_rvalid_i;
	endsequence

	sync_hold_a: assert property ((state_q == S_SYNC) |-> fetch_hold_o && !instr_ready_o)
		else $error("fetch not held during sync");

	sync_release_a: assert property ((state_q == S_SYNC) && pipe_busy_i |=> (state_q == S_SYNC))
		else $error("sync released while pipeline busy");

	sync_local_a: assert property ((state_q == S_SYNC) |-> !mem_req_o && !gpr_wr_en_o && !fpr_wr_en_o)
		else $error("sync caused outside activity");

	ea_form_a: assert property (take_load |=> mem_req_o && mem_addr_o == $past(exp_ea))
		else $error("effective address wrong");

	byte_zero_a: assert property (gpr_wr_en_o && kind_q == LDS_K_BYTE |-> gpr_wr_data_o[31:8] == 24'h0)
		else $error("byte load upper bits not clear");

	half_sign_a: assert property (gpr_wr_en_o && kind_q == LDS_K_HALF |-> gpr_wr_data_o[31:16] == {16{gpr_wr_data_o[15]}})
		else $error("halfword not sign extended");

	bad_form_a: assert property (instr_ready_o && instr_valid_i && dec_ok && bad_form |=> illegal_o && !mem_req_o)
		else $error("invalid form accepted");

	base_upd_a: assert property (data_back ##1 upd_q |-> base_wr_en_o && base_wr_data_o == mem_addr_o)
		else $error("base not updated with address");

	base_keep_a: assert property ((gpr_wr_en_o || fpr_wr_en_o) && !upd_q |-> !base_wr_en_o)
		else $error("base written by non-update load");

	dbl_pass_a: assert property (data_back ##0 (kind_q == LDS_K_DBL) |=> fpr_wr_en_o && fpr_wr_data_o == $past(mem_rdata_i))
		else $error("doubleword altered");

	write_late_a: assert property ((gpr_wr_en_o || fpr_wr_en_o) |-> $past(state_q) == S_WAIT && $past(mem_rvalid_i))
		else $error("target written before data");

	one_read_a: assert property (mem_req_o && mem_ready_i |=> !mem_req_o ##1 !mem_req_o)
		else $error("second read issued");

	req_stable_a: assert property (req_held |=> mem_req_o && $stable(mem_addr_o) && $stable(mem_size_o))
		else $error("request changed before accept");
endmodule

//--- core/lds_ea.sv
// Effective address adder of the load decode block.
`timescale 1ns/1ps
module lds_ea
	import lds_pkg::*;
(
	lds_ld_if.addr ld
);
	logic [31:0] base_eff;
	logic [31:0] offset;

	always_comb begin
		base_eff = ld.zero_base ? ADDR_RST : ld.base_val;
		offset = ld.use_index ? ld.index_val : sign_extend_fn(ld.disp);
		ld.ea = base_eff + offset;
	end
endmodule

//--- core/lds_fmt.sv
// Formats a returned memory datum into the target register layout.
`timescale 1ns/1ps
module lds_fmt
	import lds_pkg::*;
(
	lds_ld_if.fmt ld
);
	// ------------------------------------------------------------------
	// Single to double conversion
	// ------------------------------------------------------------------
	function automatic logic [63:0] to_double(input logic [31:0] w);
		logic [7:0] e;
		logic [22:0] f;
		logic [22:0] nf;
		logic [4:0] p;
		logic [10:0] de;
		e = w[30:23];
		f = w[22:0];
		p = 5'h0;
		for (int i = 0; i < 23; i++) begin
			if (f[i]) begin
				p = 5'(i);
			end
		end
		nf = 23'(f << (5'd23 - p));
		de = DEN_EXP_BASE + {6'h0, p};
		if (e == SGL_EXP_MAX) begin
			to_double = {w[31], DBL_EXP_MAX, f, 29'h0};
		end else if (e != 8'h0) begin
			to_double = {w[31], EXP_ADJ + {3'h0, e}, f, 29'h0};
		end else if (f == 23'h0) begin
			to_double = {w[31], 63'h0};
		end else begin
			// A denormal single becomes a normal double.
			to_double = {w[31], de, nf, 29'h0};
		end
	endfunction

	always_comb begin
		unique case (ld.kind)
			LDS_K_BYTE: ld.result = {56'h0, ld.raw[7:0]};
			LDS_K_HALF: ld.result = {32'h0, sign_extend_fn(ld.raw[15:0])};
			LDS_K_SGL: ld.result = to_double(ld.raw[31:0]);
			LDS_K_DBL: ld.result = ld.raw;
		endcase
	end
endmodule

//--- core/lds_ld_if.sv
// Operand and datum signals between the load controller and its helpers.
`timescale 1ns/1ps
interface lds_ld_if;
	logic [31:0] base_val;
	logic [31:0] index_val;
	logic [15:0] disp;
	logic use_index;
	logic zero_base;
	logic [31:0] ea;
	lds_pkg::lds_kind_t kind;
	logic [63:0] raw;
	logic [63:0] result;
	modport ctl (output base_val, index_val, disp, use_index, zero_base,
		kind, raw, input ea, result);
	modport addr (input base_val, index_val, disp, use_index, zero_base,
		output ea);
	modport fmt (input kind, raw, output result);
endinterface

//--- core/lds_pkg.sv
// Shared constants, types and helpers of the load decode and fetch sync block.
package lds_pkg;

	// ------------------------------------------------------------------
	// Instruction fields
	// ------------------------------------------------------------------
	localparam int OPC_HI = 31;
	localparam int OPC_LO = 26;
	localparam int TGT_HI = 25;
	localparam int TGT_LO = 21;
	localparam int BASE_HI = 20;
	localparam int BASE_LO = 16;
	localparam int IDX_HI = 15;
	localparam int IDX_LO = 11;
	localparam int XO_HI = 10;
	localparam int XO_LO = 1;
	localparam int DISP_HI = 15;
	localparam int DISP_LO = 0;

	// ------------------------------------------------------------------
	// Opcodes
	// ------------------------------------------------------------------
	localparam logic [5:0] OP_BYTE = 6'h22;
	localparam logic [5:0] OP_BYTE_U = 6'h23;
	localparam logic [5:0] OP_HALF = 6'h2A;
	localparam logic [5:0] OP_SGL = 6'h30;
	localparam logic [5:0] OP_SGL_U = 6'h31;
	localparam logic [5:0] OP_DBL = 6'h32;
	localparam logic [5:0] OP_DBL_U = 6'h33;
	localparam logic [5:0] OP_EXT = 6'h1F;
	localparam logic [5:0] OP_SYNC = 6'h13;
	localparam logic [9:0] XO_BYTE_UX = 10'h077;
	localparam logic [9:0] XO_BYTE_X = 10'h057;
	localparam logic [9:0] XO_DBL_UX = 10'h277;
	localparam logic [9:0] XO_DBL_X = 10'h257;
	localparam logic [9:0] XO_SGL_UX = 10'h237;
	localparam logic [9:0] XO_SGL_X = 10'h217;
	localparam logic [9:0] XO_SYNC = 10'h096;

	// ------------------------------------------------------------------
	// Reset values and conversion constants
	// ------------------------------------------------------------------
	localparam logic [63:0] DATA_RST = 64'h0;
	localparam logic [31:0] ADDR_RST = 32'h0;
	localparam logic [4:0] REG_RST = 5'h0;
	localparam logic [7:0] SGL_EXP_MAX = 8'hFF;
	localparam logic [10:0] DBL_EXP_MAX = 11'h7FF;
	localparam logic [10:0] EXP_ADJ = 11'h380;
	localparam logic [10:0] DEN_EXP_BASE = 11'h36A;

	typedef enum logic [1:0] {LDS_SZ_1, LDS_SZ_2, LDS_SZ_4, LDS_SZ_8}
		lds_size_t;
	typedef enum logic [1:0] {LDS_K_BYTE, LDS_K_HALF, LDS_K_SGL, LDS_K_DBL}
		lds_kind_t;

	function automatic logic [31:0] sign_extend_fn(input logic [15:0] v);
		sign_extend_fn = {{16{v[15]}}, v};
	endfunction

	function automatic lds_size_t lds_size_of(input lds_kind_t k);
		unique case (k)
			LDS_K_BYTE: lds_size_of = LDS_SZ_1;
			LDS_K_HALF: lds_size_of = LDS_SZ_2;
			LDS_K_SGL: lds_size_of = LDS_SZ_4;
			LDS_K_DBL: lds_size_of = LDS_SZ_8;
		endcase
	endfunction

endpackage

//--- tb/lds_core_bench.sv
// Self-checking bench for the load decode and fetch sync controller.
`timescale 1ns/1ps
module lds_core_bench
	import lds_pkg::*;
;
	typedef struct {
		logic [1:0] k;
		logic [4:0] t;
		logic [63:0] data;
		logic upd;
		logic [4:0] a;
		logic [31:0] ea;
	} lds_exp_t;

	logic clk, reset, instr_valid_i, pipe_busy_i, slow;
	logic instr_ready_o, illegal_o, fetch_hold_o, mem_req_o;
	logic mem_ready_i, mem_rvalid_i, gpr_wr_en_o, fpr_wr_en_o, base_wr_en_o;
	logic [31:0] instr_i, mem_addr_o, gpr_wr_data_o, base_wr_data_o;
	logic [4:0] base_sel_o, index_sel_o, gpr_wr_idx_o, fpr_wr_idx_o;
	logic [4:0] base_wr_idx_o;
	logic [63:0] mem_rdata_i, fpr_wr_data_o;
	lds_size_t mem_size_o;
	logic [31:0] gpr [32];
	lds_exp_t eq[$];
	logic [33:0] aq[$];
	int fail_count, n_checks;
	logic [15:0] forms [13] = '{{OP_BYTE, 10'h0}, {OP_BYTE_U, 10'h0},
		{OP_HALF, 10'h0}, {OP_SGL, 10'h0}, {OP_SGL_U, 10'h0},
		{OP_DBL, 10'h0}, {OP_DBL_U, 10'h0}, {OP_EXT, XO_BYTE_X},
		{OP_EXT, XO_BYTE_UX}, {OP_EXT, XO_SGL_X}, {OP_EXT, XO_SGL_UX},
		{OP_EXT, XO_DBL_X}, {OP_EXT, XO_DBL_UX}};

	lds_core dut_u (.clk, .reset, .instr_valid_i, .instr_i, .instr_ready_o,
		.illegal_o, .pipe_busy_i, .fetch_hold_o, .base_sel_o, .index_sel_o,
		.base_val_i(gpr[base_sel_o]), .index_val_i(gpr[index_sel_o]),
		.mem_req_o, .mem_addr_o, .mem_size_o, .mem_ready_i, .mem_rvalid_i,
		.mem_rdata_i, .gpr_wr_en_o, .gpr_wr_idx_o, .gpr_wr_data_o,
		.fpr_wr_en_o, .fpr_wr_idx_o, .fpr_wr_data_o, .base_wr_en_o,
		.base_wr_idx_o, .base_wr_data_o);

	lds_mem_model mem_u (.clk, .reset, .slow, .req(mem_req_o),
		.addr(mem_addr_o), .size(mem_size_o), .ready(mem_ready_i),
		.rvalid(mem_rvalid_i), .rdata(mem_rdata_i));

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	task automatic check(input string what, input logic [71:0] seen,
		input logic [71:0] want);
		n_checks++;
		if (seen !== want) begin
			fail_count++;
			$display("Error %s expected %h seen %h", what, want, seen);
		end
	endtask

	task automatic conclude();
		$display("Checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	function automatic logic [63:0] to_double(input logic [31:0] w);
		logic [23:0] m;
		logic [10:0] x;
		m = {1'b0, w[22:0]};
		x = 11'h381;
		if (w[30:23] == 8'h00 && m == 24'h0)
			return {w[31], 63'h0};
		if (w[30:23] == 8'hFF)
			return {w[31], 11'h7FF, w[22:0], 29'h0};
		if (w[30:23] != 8'h00)
			return {w[31], {3'h0, w[30:23]} + 11'h380, w[22:0], 29'h0};
		// A denormal is shifted up until its leading one is the hidden bit.
		while (!m[23]) begin
			m = m << 1;
			x = x - 11'h1;
		end
		return {w[31], x, m[22:0], 29'h0};
	endfunction

	// Zeros, infinities, denormals and normal numbers in even measure.
	function automatic logic [31:0] pick_single();
		logic [31:0] v;
		v = $urandom;
		if (v[1:0] == 2'h0)
			v = {v[31], 31'h0};
		else if (v[1:0] == 2'h1)
			v = {v[31], 8'hFF, 23'h0};
		else if (v[1:0] == 2'h2)
			v[30:23] = 8'h00;
		else if (v[30:23] inside {8'h00, 8'hFF})
			v[30:23] = 8'h81;
		return v;
	endfunction

	// Offers one word, holds it until taken, then waits for idle again.
	task automatic issue(input logic [31:0] w);
		int n;
		@(posedge clk);
		#1;
		instr_i = w;
		instr_valid_i = 1'b1;
		n = 0;
		while (instr_ready_o !== 1'b1 && n < 50) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n == 50)
			check("ready_wait", instr_ready_o, 1'b1);
		@(posedge clk);
		#1;
		instr_valid_i = 1'b0;
		instr_i = $urandom;
		n = 0;
		while (instr_ready_o !== 1'b1 && n < 50) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n == 50)
			check("ready_wait", instr_ready_o, 1'b1);
	endtask

	task automatic run_load(input logic [5:0] op, input logic [9:0] xo,
		input logic [4:0] t, input logic [4:0] a, input logic [4:0] b,
		input logic [15:0] d);
		lds_exp_t e;
		logic ix;
		logic [1:0] sz;
		logic [63:0] raw;
		ix = (op == OP_EXT);
		// Update forms have the odd primary or bit 5 of the extended code set.
		e.upd = ix ? xo[5] : op[0];
		e.k = 2'd0;
		e.t = t;
		e.a = a;
		e.ea = ((a == 5'h0 && !e.upd) ? 32'h0 : gpr[a])
			+ (ix ? gpr[b] : {{16{d[15]}}, d});
		if (op == OP_HALF)
			sz = 2'd1;
		else if (op inside {OP_SGL, OP_SGL_U} || xo inside {XO_SGL_X, XO_SGL_UX})
			sz = 2'd2;
		else if (op inside {OP_DBL, OP_DBL_U} || xo inside {XO_DBL_X, XO_DBL_UX})
			sz = 2'd3;
		else
			sz = 2'd0;
		if (sz == 2'd2)
			mem_u.store[e.ea] = {32'h5A5A5A5A, pick_single()};
		raw = mem_u.rd(e.ea);
		case (sz)
			2'd0: e.data = {56'h0, raw[7:0]};
			2'd1: e.data = {32'h0, {16{raw[15]}}, raw[15:0]};
			2'd2: begin
				e.k = 2'd1;
				e.data = to_double(raw[31:0]);
			end
			default: begin
				e.k = 2'd1;
				e.data = raw;
			end
		endcase
		eq.push_back(e);
		aq.push_back({sz, e.ea});
		issue(ix ? {op, t, a, b, xo, 1'b0} : {op, t, a, d});
	endtask

	// ------------------------------------------------------------------
	// Result watcher
	// ------------------------------------------------------------------
	always @(negedge clk) begin
		lds_exp_t e;
		if (!reset && (gpr_wr_en_o | fpr_wr_en_o | illegal_o) === 1'b1) begin
			e.k = 2'd3;
			if (eq.size() > 0)
				e = eq.pop_front();
			check("event", {illegal_o, fpr_wr_en_o, gpr_wr_en_o}, 3'b001 << e.k);
			if (e.k == 2'd0)
				check("gpr", {gpr_wr_idx_o, gpr_wr_data_o}, {e.t, e.data[31:0]});
			if (e.k == 2'd1)
				check("fpr", {fpr_wr_idx_o, fpr_wr_data_o}, {e.t, e.data});
			if (e.k < 2'd2)
				check("base", {base_wr_en_o, e.upd ? {base_wr_idx_o,
					base_wr_data_o} : 37'h0}, {e.upd, e.upd ? {e.a, e.ea} : 37'h0});
		end
		if (!reset && (mem_req_o & mem_ready_i) === 1'b1) begin
			if (aq.size() == 0)
				check("mem_req", 1'b1, 1'b0);
			else
				check("mem_req", {mem_size_o, mem_addr_o}, aq.pop_front());
		end
	end

	// ------------------------------------------------------------------
	// Clock, watchdog and tests
	// ------------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		$display("Error watchdog expected finish seen hang");
		conclude();
	end

	initial begin
		lds_exp_t e;
		logic [31:0] r;
		logic [4:0] t, a;
		logic upd;
		reset = 1'b1;
		instr_valid_i = 1'b0;
		instr_i = 32'h0;
		pipe_busy_i = 1'b0;
		slow = 1'b0;
		fail_count = 0;
		n_checks = 0;
		void'($urandom(90));
		foreach (gpr[i])
			gpr[i] = $urandom;
		repeat (5) @(posedge clk);
		#1;
		reset = 1'b0;
		foreach (forms[i]) begin
			for (int j = 0; j < 4; j++) begin
				r = $urandom;
				slow = r[31];
				t = r[4:0];
				a = r[9:5];
				upd = (forms[i][15:10] == OP_EXT) ? forms[i][5] : forms[i][10];
				if (j == 0 && !upd)
					a = 5'h0;
				if (upd && a == 5'h0)
					a = 5'h1;
				if (upd && a == t)
					t = ~a;
				run_load(forms[i][15:10], forms[i][9:0], t, a, r[14:10], r[30:15]);
			end
		end
		$display("Test loads done");
		e.k = 2'd2;
		foreach (forms[i]) begin
			if ((forms[i][15:10] == OP_EXT) ? forms[i][5] : forms[i][10]) begin
				eq.push_back(e);
				issue({forms[i][15:10], 5'h3, 5'h0, 5'h4, forms[i][9:0], 1'b0});
			end
		end
		eq.push_back(e);
		issue({OP_BYTE_U, 5'h7, 5'h7, 16'h0010});
		eq.push_back(e);
		issue({6'h2B, 5'h2, 5'h5, 16'h0002});
		$display("Test invalid forms done");
		for (int n = 0; n < 5; n += 4) begin
			@(posedge clk);
			#1;
			pipe_busy_i = (n > 0);
			instr_i = {OP_SYNC, 15'h0, XO_SYNC, 1'b0};
			instr_valid_i = 1'b1;
			@(negedge clk);
			check("hold_offer", fetch_hold_o, 1'b1);
			@(posedge clk);
			#1;
			instr_valid_i = 1'b0;
			repeat (n) begin
				check("hold_busy", {fetch_hold_o, instr_ready_o}, 2'b10);
				@(posedge clk);
				#1;
			end
			pipe_busy_i = 1'b0;
			@(posedge clk);
			#1;
			check("sync_done", {fetch_hold_o, instr_ready_o}, 2'b01);
			run_load(OP_BYTE, 10'h0, 5'h4, 5'h0, 5'h0, 16'h8001);
		end
		$display("Test fetch sync done");
		check("pending", eq.size() + aq.size(), 0);
		conclude();
	end
endmodule

//--- tb/lds_mem_model.sv
// Data memory model answering the load controller's read requests.
`timescale 1ns/1ps
module lds_mem_model
	import lds_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic slow,
	input wire logic req,
	input wire logic [31:0] addr,
	input wire lds_size_t size,
	output logic ready,
	output logic rvalid,
	output logic [63:0] rdata
);
	logic [63:0] store [logic [31:0]];
	logic [31:0] a_q;
	logic [1:0] s_q;

	// Stored words win; any other address reads a pattern made from itself.
	function automatic logic [63:0] rd(input logic [31:0] a);
		return store.exists(a) ? store[a] : {a ^ 32'hC3A50F1E, ~a};
	endfunction

	// ------------------------------------------------------------------
	// Read responder
	// ------------------------------------------------------------------
	// The data lines toggle in each cycle without a valid datum except the one after ready, so a controller that
	// samples them outside the answer cycle sees junk.
	initial begin
		ready = 1'b0;
		rvalid = 1'b0;
		rdata = 64'h0123456789ABCDEF;
		forever begin
			@(posedge clk);
			#1;
			rvalid = 1'b0;
			rdata = ~rdata;
			if (req === 1'b1 && reset === 1'b0) begin
				repeat (slow ? 2 : 0) begin
					@(posedge clk);
					#1;
					rdata = ~rdata;
				end
				a_q = addr;
				s_q = size;
				ready = 1'b1;
				@(posedge clk);
				#1;
				ready = 1'b0;
				repeat (slow ? 3 : 0) begin
					@(posedge clk);
					#1;
					rdata = ~rdata;
				end
				@(posedge clk);
				#1;
				// Bytes beyond the access size carry junk as well.
				rvalid = 1'b1;
				rdata = rd(a_q) ^ ((~64'h0 << (8 << s_q)) & 64'h5A5A5A5A5A5A5A5A);
			end
		end
	end
endmodule
